// ---- hdl/spisc_top.v ----
/*
 * Byte-wide serial port status and control logic with an 8-entry receive
 * FIFO. Assumes a core that reaches the registers through a paged special
 * function register port with bit writes, and pad logic that resolves each
 * pin from its output and output enable.
 */
// Behaviour
// (R1) Slave: receive empty set once buffer drained.
// (R2) Slave: receive empty low while unread byte.
// (R3) Master: receive empty always reads one.
// (R4) Slave samples MOSI at bit centre.
// (R5) Master samples MISO one cycle before bit end.
// (R6) Byte end sets done flag, interrupts, sticky.
// (R7) Data write while transmit full collides, discarded.
// (R8) Collision flag sticky; rejected byte never stored.
// (R9) Control register at 0xF8 page 0, bit addressable.
// (R10) Slave overrun when byte ends into full buffer.
// (R11) Select mode: 3-wire, 4-wire slave, single master.
// (R12) Clock polarity sets idle SCK level.
// (R13) Clock phase picks first or second edge.
// (R14) Software clears done and collision flags itself.
`timescale 1ns/1ps
`include "spisc_consts.vh"

module spisc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = `SPISC_FIFO_DEPTH,
   parameter AW = 3
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = (count_reg != DEPTH);
   assign out_valid_o = (count_reg != 0);
   assign out_data_o = mem[rd_ptr_reg];
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // spisc_fifo

module spisc_top #(
   parameter HALF_BIT = `SPISC_HALF_BIT
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire [3:0] sfr_page_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   input wire [7:0] sfr_wdata_i,
   input wire bit_wr_i,
   input wire [7:0] bit_addr_i,
   input wire bit_val_i,
   input wire int_enable_i,
   output reg [7:0] sfr_rdata_o,
   output reg irq_o,
   input wire sck_i,
   output reg sck_o,
   output reg sck_oe_o,
   input wire mosi_i,
   output reg mosi_o,
   output reg mosi_oe_o,
   input wire miso_i,
   output reg miso_o,
   output reg miso_oe_o,
   input wire slave_select_n_i,
   output reg slave_select_n_o,
   output reg slave_select_n_oe_o
);
   localparam ST_IDLE = 2'b01;
   localparam ST_BUSY = 2'b10;

   reg done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovrn_reg, txe_reg, en_reg;
   reg [1:0] smd_reg;
   reg master_reg, cpha_reg, cpol_reg;
   reg [7:0] tx_buf_reg, sh_reg;
   reg [1:0] state_reg;
   reg [7:0] div_reg;
   reg half_reg, first_reg, sel_p_reg, sck_p_reg;
   reg [2:0] bit_reg;
   reg [1:0] sck_sy_reg, mosi_sy_reg, miso_sy_reg, ss_sy_reg;
   reg push_reg;
   reg [7:0] push_data_reg;

   wire [7:0] ctrl_val = {done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovrn_reg, smd_reg, txe_reg, en_reg};
   wire pg_ok = (sfr_page_i == `SPISC_PAGE);
   wire sel_ctrl = pg_ok && (sfr_addr_i == `SPISC_ADDR_CTRL);
   wire sel_cfg = pg_ok && (sfr_addr_i == `SPISC_ADDR_CFG);
   wire sel_data = pg_ok && (sfr_addr_i == `SPISC_ADDR_DATA);
   wire bit_hit = pg_ok && bit_wr_i && (bit_addr_i[7:3] == `SPISC_ADDR_CTRL >> 3); // [R9]
   reg [7:0] wmask, wval;
   always @* begin
      wmask = 8'h00;
      wval = ctrl_val;
      if (sfr_wr_i && sel_ctrl) begin
         wmask = 8'hff;
         wval = sfr_wdata_i;
      end else if (bit_hit) begin
         wmask[bit_addr_i[2:0]] = 1'b1; // [R9]
         wval[bit_addr_i[2:0]] = bit_val_i;
      end
   end

   wire fifo_in_ready, fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire data_rd = sfr_rd_i && sel_data;
   spisc_fifo #(.WIDTH(8), .DEPTH(`SPISC_FIFO_DEPTH), .AW(3)) u_rx_fifo (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(push_reg),
      .in_ready_o(fifo_in_ready),
      .in_data_i(push_data_reg),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(data_rd),
      .out_data_o(fifo_out_data)
   );

   // Receive empty follows the FIFO head in slave mode only.
   wire rx_empty = master_reg ? 1'b1 : !fifo_out_valid; // [R1] [R2] [R3]

   // Select handling: 3-wire is always selected, 4-wire slave uses the pin.
   wire slave_sel = (smd_reg == `SPISC_SMD_3WIRE) ? 1'b1 :
                    (smd_reg == `SPISC_SMD_4SLV) ? !ss_sy_reg[1] : 1'b0; // [R11]
   wire slv_on = en_reg && !master_reg && slave_sel;
   wire sck_edge = (sck_sy_reg[1] != sck_p_reg);
   wire lead_edge = sck_edge && (sck_sy_reg[1] != cpol_reg); // [R12]
   wire smp_edge = sck_edge && (cpha_reg ? !lead_edge : lead_edge); // [R13]
   wire out_edge = sck_edge && !smp_edge;
   wire slv_load = slv_on && !sel_p_reg;
   wire mst_start = en_reg && master_reg && (state_reg == ST_IDLE) && !txe_reg && !push_reg
                    && fifo_in_ready;
   wire div_end = (div_reg == HALF_BIT - 1);
   wire mst_smp = (state_reg == ST_BUSY) && half_reg && div_end; // [R5]

   // Byte completion in either mode.
   wire slv_done = slv_on && smp_edge && (bit_reg == 3'h7);
   wire mst_done = mst_smp && (bit_reg == 3'h7);
   wire byte_done = slv_done || mst_done;
   wire [7:0] rx_byte = {sh_reg[6:0], master_reg ? miso_sy_reg[1] : mosi_sy_reg[1]};
   // Overrun is judged against the FIFO as it stands; a byte that finds it full is lost.
   wire ovrn_evt = slv_done && !fifo_in_ready; // [R10]
   wire write_collision_flag_evt = sfr_wr_i && sel_data && !txe_reg; // [R7]
   wire tx_take = sfr_wr_i && sel_data && txe_reg;
   wire tx_use = mst_start || (slv_load && !txe_reg) || (slv_done && !txe_reg);

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_sy_reg <= 2'h0;
         mosi_sy_reg <= 2'h0;
         miso_sy_reg <= 2'h0;
         ss_sy_reg <= 2'h3;
         sck_p_reg <= 1'b0;
         sel_p_reg <= 1'b0;
      end else begin
         sck_sy_reg <= {sck_sy_reg[0], sck_i};
         mosi_sy_reg <= {mosi_sy_reg[0], mosi_i};
         miso_sy_reg <= {miso_sy_reg[0], miso_i};
         ss_sy_reg <= {ss_sy_reg[0], slave_select_n_i};
         sck_p_reg <= sck_sy_reg[1];
         sel_p_reg <= slv_on;
      end
   end

   // Flags: a hardware set in the same cycle as a software clear wins.
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_reg <= 1'b0;
         write_collision_flag_reg <= 1'b0;
         mode_fault_flag_reg <= 1'b0;
         ovrn_reg <= 1'b0;
         smd_reg <= `SPISC_SMD_RST;
         txe_reg <= 1'b1;
         en_reg <= 1'b0;
         master_reg <= 1'b0;
         cpha_reg <= 1'b0;
         cpol_reg <= 1'b0;
         tx_buf_reg <= 8'h00;
      end else begin
         if (byte_done) begin
            done_reg <= 1'b1; // [R6]
         end else if (wmask[`SPISC_BIT_DONE]) begin
            done_reg <= wval[`SPISC_BIT_DONE]; // [R14]
         end
         if (write_collision_flag_evt) begin
            write_collision_flag_reg <= 1'b1; // [R7] [R8]
         end else if (wmask[`SPISC_BIT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_reg <= wval[`SPISC_BIT_WRITE_COLLISION_FLAG]; // [R14]
         end
         if (ovrn_evt) begin
            ovrn_reg <= 1'b1; // [R10]
         end else if (wmask[`SPISC_BIT_OVRN]) begin
            ovrn_reg <= wval[`SPISC_BIT_OVRN];
         end
         if (wmask[`SPISC_BIT_MODE_FAULT_FLAG]) begin
            mode_fault_flag_reg <= wval[`SPISC_BIT_MODE_FAULT_FLAG];
         end
         if (wmask[`SPISC_BIT_SMD_HI]) begin
            smd_reg[1] <= wval[`SPISC_BIT_SMD_HI];
         end
         if (wmask[`SPISC_BIT_SMD_LO]) begin
            smd_reg[0] <= wval[`SPISC_BIT_SMD_LO];
         end
         if (wmask[`SPISC_BIT_EN]) begin
            en_reg <= wval[`SPISC_BIT_EN];
         end
         if (sfr_wr_i && sel_cfg) begin
            master_reg <= sfr_wdata_i[`SPISC_CFG_MASTER];
            cpha_reg <= sfr_wdata_i[`SPISC_CFG_CPHA];
            cpol_reg <= sfr_wdata_i[`SPISC_CFG_CPOL];
         end
         // The colliding byte never reaches the buffer.
         if (tx_take) begin
            tx_buf_reg <= sfr_wdata_i; // [R8]
            txe_reg <= 1'b0;
         end else if (tx_use) begin
            txe_reg <= 1'b1;
         end
      end
   end

   // Shift engine, master timing and slave edge tracking.
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_IDLE;
         sh_reg <= 8'h00;
         div_reg <= 8'h00;
         half_reg <= 1'b0;
         bit_reg <= 3'h0;
         first_reg <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= 8'h00;
         mosi_o <= 1'b0;
         miso_o <= 1'b0;
         sck_o <= 1'b0;
      end else begin
         push_reg <= byte_done && fifo_in_ready;
         if (byte_done) begin
            push_data_reg <= rx_byte;
         end
         case (state_reg)
            ST_IDLE: begin
               sck_o <= cpol_reg; // [R12]
               div_reg <= 8'h00;
               half_reg <= 1'b0;
               if (mst_start) begin
                  sh_reg <= tx_buf_reg;
                  mosi_o <= tx_buf_reg[7];
                  bit_reg <= 3'h0;
                  sck_o <= cpol_reg ^ cpha_reg; // [R13]
                  state_reg <= ST_BUSY;
               end else if (slv_load || (slv_done && !txe_reg)) begin
                  sh_reg <= txe_reg ? 8'h00 : tx_buf_reg;
                  miso_o <= txe_reg ? 1'b0 : tx_buf_reg[7];
                  bit_reg <= 3'h0;
                  first_reg <= 1'b1;
               end else if (slv_on && smp_edge) begin
                  sh_reg <= rx_byte; // [R4]
                  bit_reg <= bit_reg + 3'h1;
                  first_reg <= 1'b0;
               end else if (slv_on && out_edge) begin
                  if (first_reg) begin
                     first_reg <= 1'b0;
                  end else begin
                     miso_o <= sh_reg[7];
                  end
               end else if (!slv_on) begin
                  bit_reg <= 3'h0;
               end
            end
            ST_BUSY: begin
               if (div_end) begin
                  div_reg <= 8'h00;
                  half_reg <= !half_reg;
                  sck_o <= !sck_o;
                  if (half_reg) begin
                     sh_reg <= rx_byte; // [R5]
                     mosi_o <= sh_reg[6];
                     bit_reg <= bit_reg + 3'h1;
                     if (bit_reg == 3'h7) begin
                        sck_o <= cpol_reg;
                        state_reg <= ST_IDLE;
                     end
                  end
               end else begin
                  div_reg <= div_reg + 8'h01;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Pin enables, register read data and the interrupt line.
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sck_oe_o <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_oe_o <= 1'b0;
         slave_select_n_o <= 1'b1;
         slave_select_n_oe_o <= 1'b0;
         sfr_rdata_o <= 8'h00;
         irq_o <= 1'b0;
      end else begin
         sck_oe_o <= en_reg && master_reg;
         mosi_oe_o <= en_reg && master_reg;
         miso_oe_o <= slv_on;
         slave_select_n_oe_o <= en_reg && smd_reg[1]; // [R11]
         slave_select_n_o <= smd_reg[0];
         irq_o <= int_enable_i && (done_reg || write_collision_flag_reg || mode_fault_flag_reg || ovrn_reg); // [R6] [R7]
         if (sfr_rd_i && sel_ctrl) begin
            sfr_rdata_o <= ctrl_val;
         end else if (sfr_rd_i && sel_cfg) begin
            sfr_rdata_o <= {1'b0, master_reg, cpha_reg, cpol_reg, 3'h0, rx_empty};
         end else if (data_rd) begin
            sfr_rdata_o <= fifo_out_valid ? fifo_out_data : 8'h00;
         end else if (sfr_rd_i) begin
            sfr_rdata_o <= 8'h00;
         end
      end
   end
endmodule // spisc_top

// ---- pkg/spisc_consts.vh ----
/*
 * Constants of the serial port status and control block: register
 * addresses, field positions, reset values and the master clock divider.
 * Assumes inclusion by the single design file of the block.
 */
`ifndef SPISC_CONSTS_VH
`define SPISC_CONSTS_VH
`define SPISC_PAGE 4'h0
`define SPISC_ADDR_CTRL 8'hf8
`define SPISC_ADDR_CFG 8'ha1
`define SPISC_ADDR_DATA 8'ha3
`define SPISC_BIT_DONE 7
`define SPISC_BIT_WRITE_COLLISION_FLAG 6
`define SPISC_BIT_MODE_FAULT_FLAG 5
`define SPISC_BIT_OVRN 4
`define SPISC_BIT_SMD_HI 3
`define SPISC_BIT_SMD_LO 2
`define SPISC_BIT_TXE 1
`define SPISC_BIT_EN 0
`define SPISC_CFG_MASTER 6
`define SPISC_CFG_CPHA 5
`define SPISC_CFG_CPOL 4
`define SPISC_SMD_RST 2'h1
`define SPISC_SMD_3WIRE 2'h0
`define SPISC_SMD_4SLV 2'h1
`define SPISC_SMD_4MST 2'h2
`define SPISC_HALF_BIT 4
`define SPISC_FIFO_DEPTH 8
`endif

// ---- dv/spisc_sva.sv ----
/* Port assertions for the serial port status block.
   Assumes the default register map and a single clock domain. */
`timescale 1ns/1ps
module spisc_sva #(
   parameter HALF_BIT = 4
) (
   input wire clk_i,
   input wire arst_n_i,
   input wire [3:0] sfr_page_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire sfr_rd_i,
   input wire bit_wr_i,
   input wire int_enable_i,
   input wire [7:0] sfr_rdata_o,
   input wire irq_o,
   input wire sck_o,
   input wire sck_oe_o,
   input wire mosi_oe_o,
   input wire miso_oe_o
);
   reg [1:0] seen_reg;
   reg rd_ctl_reg;
   reg sck_q_reg;
   reg [3:0] gap_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_rd0; sfr_rd_i && sfr_page_i == 4'h0; endsequence
   sequence s_ctl_rd; s_rd0 ##0 sfr_addr_i == 8'hf8 && !sfr_wr_i && !bit_wr_i; endsequence
   // Any write may clear flags, so the remembered set is dropped on every write.
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seen_reg <= 2'h0;
         rd_ctl_reg <= 1'b0;
         sck_q_reg <= 1'b0;
         gap_reg <= 4'hf;
      end else begin
         // A read that shares its edge with a write may show flags that the write clears.
         rd_ctl_reg <= sfr_rd_i && !sfr_wr_i && !bit_wr_i && sfr_page_i == 4'h0
                       && sfr_addr_i == 8'hf8;
         if (sfr_wr_i || bit_wr_i) begin
            seen_reg <= 2'h0;
         end else if (rd_ctl_reg) begin
            seen_reg <= sfr_rdata_o[7:6];
         end
         sck_q_reg <= sck_o;
         gap_reg <= (sck_o != sck_q_reg) ? 4'h0 : gap_reg + {3'h0, gap_reg != 4'hf};
      end
   end
   a_unmapped_read: assert property (
      s_rd0 ##0 sfr_addr_i != 8'hf8 && sfr_addr_i != 8'ha1 && sfr_addr_i != 8'ha3
      |=> sfr_rdata_o == 8'h00) else $error("unmapped read returned data");
   a_page_read: assert property (
      sfr_rd_i && sfr_page_i != 4'h0 |=> sfr_rdata_o == 8'h00) else $error("other page read data");
   a_rdata_hold: assert property (
      !sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved without a read");
   a_irq_gated: assert property (
      !int_enable_i |=> !irq_o) else $error("interrupt while disabled");
   a_master_rxe: assert property (
      s_rd0 ##0 sfr_addr_i == 8'ha1 |=> !sfr_rdata_o[6] || sfr_rdata_o[0])
      else $error("receive empty low in master mode");
   a_flags_sticky: assert property (
      s_ctl_rd |=> (sfr_rdata_o[7:6] & seen_reg) == seen_reg) else $error("flag cleared by hardware");
   a_master_pins: assert property (
      sck_oe_o |-> mosi_oe_o && !miso_oe_o) else $error("pin drivers disagree in master mode");
   a_half_bit: assert property (
      sck_oe_o && sck_o != sck_q_reg |-> gap_reg >= HALF_BIT - 1) else $error("clock phase too short");
endmodule // spisc_sva
bind spisc_top spisc_sva #(.HALF_BIT(HALF_BIT)) spisc_sva_inst (.clk_i, .arst_n_i, .sfr_page_i,
   .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .bit_wr_i, .int_enable_i, .sfr_rdata_o, .irq_o, .sck_o,
   .sck_oe_o, .mosi_oe_o, .miso_oe_o);

// ---- dv/spisc_peer.sv ----
/* Far-side device: a mode 0 slave answering the port as master, and a
   200 ns master driving it as slave. Assumes the bench resolves pins. */
`timescale 1ns/1ps
module spisc_peer (
   input wire sck_i,
   input wire mosi_i,
   input wire miso_i,
   input wire slave_select_n_i,
   output reg sck_o,
   output reg mosi_o,
   output reg miso_o,
   output reg slave_select_n_o
);
   reg [7:0] tx_reg;
   reg [7:0] rx_reg;
   integer i;
   initial begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
      miso_o = 1'b0;
      slave_select_n_o = 1'b1;
      tx_reg = 8'h00;
      rx_reg = 8'h00;
   end
   task load(input [7:0] b);
      begin
         tx_reg = b;
         miso_o = b[7];
      end
   endtask
   always @(posedge sck_i) if (!slave_select_n_i) rx_reg = {rx_reg[6:0], mosi_i};
   always @(negedge sck_i) if (!slave_select_n_i) begin
      tx_reg = {tx_reg[6:0], 1'b0};
      miso_o = tx_reg[7];
   end
   // A released line has no pull, so it must not keep showing its last level.
   always @(posedge slave_select_n_i) miso_o = ~miso_o;
   // Sampling late in the high phase leaves room for the port's input synchroniser.
   task xfer(input [7:0] b, output [7:0] r);
      begin
         slave_select_n_o = 1'b0;
         #100;
         for (i = 7; i >= 0; i = i - 1) begin
            mosi_o = b[i];
            #100 sck_o = 1'b1;
            #90 r = {r[6:0], miso_i};
            #10 sck_o = 1'b0;
         end
         slave_select_n_o = 1'b1;
         mosi_o = ~mosi_o;
      end
   endtask
endmodule // spisc_peer

// ---- dv/testbench.sv ----
/* Self-checking bench: register map, slave reception into the FIFO,
   collisions and master transfers. Assumes default parameters. */
`timescale 1ns/1ps
module testbench;
   reg clk_i, arst_n_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_val_i, int_enable_i;
   reg [3:0] sfr_page_i;
   reg [7:0] sfr_addr_i, sfr_wdata_i, bit_addr_i, v, r;
   wire [7:0] sfr_rdata_o;
   wire irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   wire slave_select_n_o, slave_select_n_oe_o, p_sck, p_mosi, p_miso, p_ss;
   wire sck_i = sck_oe_o ? sck_o : p_sck;
   wire mosi_i = mosi_oe_o ? mosi_o : p_mosi;
   wire miso_i = miso_oe_o ? miso_o : p_miso;
   wire slave_select_n_i = slave_select_n_oe_o ? slave_select_n_o : p_ss;
   integer fail_count, check_count, cycles, m;
   spisc_top spisc_top_inst (.clk_i, .arst_n_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
      .sfr_wdata_i, .bit_wr_i, .bit_addr_i, .bit_val_i, .int_enable_i, .sfr_rdata_o, .irq_o,
      .sck_i, .sck_o, .sck_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o,
      .slave_select_n_i, .slave_select_n_o, .slave_select_n_oe_o);
   spisc_peer spisc_peer_inst (.sck_i, .mosi_i, .miso_i, .slave_select_n_i, .sck_o(p_sck),
      .mosi_o(p_mosi), .miso_o(p_miso), .slave_select_n_o(p_ss));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t ns: got %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task acc(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_i);
         #2 sfr_addr_i = a;
         sfr_wdata_i = d;
         sfr_wr_i = w;
         sfr_rd_i = !w;
         @(posedge clk_i);
         #2 sfr_wr_i = 1'b0;
         sfr_rd_i = 1'b0;
         v = sfr_rdata_o;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] exp);
      begin
         acc(1'b0, a, 8'h00);
         chk(v, exp);
      end
   endtask
   task bitw(input [2:0] n, input b);
      begin
         @(posedge clk_i);
         #2 bit_addr_i = 8'hf8 + {5'h00, n};
         bit_val_i = b;
         bit_wr_i = 1'b1;
         @(posedge clk_i);
         #2 bit_wr_i = 1'b0;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d, mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 10000) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t ns: run timed out", $time);
         final_report;
      end
   end
   initial begin
      {arst_n_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_val_i, sfr_page_i} = 9'h000;
      {sfr_addr_i, sfr_wdata_i, bit_addr_i} = 24'h000000;
      int_enable_i = 1'b1;
      fail_count = 0;
      check_count = 0;
      cycles = 0;
      repeat (5) @(posedge clk_i);
      #2 arst_n_i = 1'b1;
      rdc(8'hf8, 8'h06);
      rdc(8'ha1, 8'h01);
      rdc(8'h55, 8'h00);
      sfr_page_i = 4'h1;
      rdc(8'hf8, 8'h00);
      sfr_page_i = 4'h0;
      bitw(3'h0, 1'b1);
      rdc(8'hf8, 8'h07);
      chk({7'h00, miso_oe_o}, 8'h00);
      $display("register map test done");
      // Nine bytes into an eight-entry buffer: the last one must overrun.
      for (m = 0; m < 9; m = m + 1) begin
         spisc_peer_inst.xfer(8'ha0 + m[7:0], r);
         #400;
         if (m == 0) begin
            rdc(8'hf8, 8'h87);
            rdc(8'ha1, 8'h00);
            bitw(3'h7, 1'b0);
            rdc(8'hf8, 8'h07);
         end
      end
      rdc(8'hf8, 8'h97);
      chk({7'h00, irq_o}, 8'h01);
      int_enable_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #2 chk({7'h00, irq_o}, 8'h00);
      int_enable_i = 1'b1;
      for (m = 0; m < 8; m = m + 1) rdc(8'ha3, 8'ha0 + m[7:0]);
      rdc(8'ha1, 8'h01);
      rdc(8'ha3, 8'h00);
      acc(1'b1, 8'hf8, 8'h07);
      $display("slave receive test done");
      acc(1'b1, 8'ha3, 8'h3c);
      rdc(8'hf8, 8'h05);
      acc(1'b1, 8'ha3, 8'hc3);
      rdc(8'hf8, 8'h45);
      spisc_peer_inst.xfer(8'h00, r);
      #400 chk(r, 8'h3c);
      rdc(8'hf8, 8'hc7);
      acc(1'b1, 8'hf8, 8'h06);
      acc(1'b0, 8'ha3, 8'h00);
      acc(1'b1, 8'hf8, 8'h01);
      @(posedge clk_i);
      #2 chk({7'h00, miso_oe_o}, 8'h01);
      $display("collision test done");
      for (m = 0; m < 4; m = m + 1) begin
         acc(1'b1, 8'ha1, {2'h1, m[1:0], 4'h0});
         acc(1'b1, 8'hf8, 8'h09);
         repeat (2) @(posedge clk_i);
         #2 chk({7'h00, sck_o}, {7'h00, m[0]});
         chk({7'h00, slave_select_n_o}, 8'h00);
         spisc_peer_inst.load(8'h5a);
         acc(1'b1, 8'ha3, 8'h96);
         repeat (2) @(posedge clk_i);
         #2 chk({7'h00, sck_o}, {7'h00, m[0] ^ m[1]});
         repeat (70) @(posedge clk_i);
         rdc(8'hf8, 8'h8b);
         rdc(8'ha1, {2'h1, m[1:0], 4'h1});
         acc(1'b0, 8'ha3, 8'h00);
         if (m == 0) begin
            chk(v, 8'h5a);
            chk(spisc_peer_inst.rx_reg, 8'h96);
         end
         acc(1'b1, 8'hf8, 8'h09);
      end
      $display("master mode test done");
      final_report;
   end
endmodule // testbench
